/* File: pkg/gtc_params.svh */
// Register map, field positions and timing constants of the gated timer
// Summary of operation
// - Sixteen-bit up-counter, byte writes load it immediately
// - Internal clock counts once per instruction cycle
// - Counts only when on, gated if enabled
// - Clock source chosen by clock-select register
// - Raw oscillator source counts four per instruction
// - Gate sources may arrive asynchronously
// - External input counts on its rising edges
// - Falling edge required before first counted rise
// - Prescaler divides by one, two, four, eight
// - Prescaler hidden, cleared by any count write
// - Set sync-control bit skips phase synchronisation
// - Async external counting runs in sleep, wakes
// - Mode switch may drop or add one
// - Count reads always coherent while running
// - Gate enable bit and gate polarity bit
// - Gated count advances only when level matches polarity
// - Gate mode off means count every clock
// - Wraps all ones to zero, sets flag
`ifndef GTC_PARAMS_SVH
`define GTC_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define GTC_OFF_LOW 8'h00
`define GTC_OFF_HIGH 8'h04
`define GTC_OFF_CTRL 8'h08
`define GTC_OFF_GATE 8'h0C
`define GTC_OFF_CSEL 8'h10
`define GTC_OFF_STAT 8'h14

// ==========================================================
// Field positions
`define GTC_CTL_ON 0
`define GTC_CTL_ASYNC 2
`define GTC_CTL_PS_LO 4
`define GTC_CTL_PS_HI 5
`define GTC_GC_LVL 2
`define GTC_GC_POL 6
`define GTC_GC_EN 7
`define GTC_CS_LO 0
`define GTC_CS_HI 1
`define GTC_GS_LO 4
`define GTC_GS_HI 6
`define GTC_ST_OVF 0

// ==========================================================
// Reset values
`define GTC_RST_BYTE 8'h00
`define GTC_RST_PS 3'h0

// ==========================================================
// Timing
`define GTC_CLK_NS 10
`define GTC_INSTR_NS 40
`define GTC_INSTR_CYC ((`GTC_INSTR_NS + `GTC_CLK_NS - 1) / `GTC_CLK_NS)

`endif

/* File: pkg/gtc_pkg.sv */
// Types shared by the gated timer
package gtc_pkg;

	// ======================================================
	// Clock source codes
	typedef enum logic [1:0] {
		GTC_CS_INSTR = 2'h0,
		GTC_CS_OSC = 2'h1,
		GTC_CS_EXT = 2'h2,
		GTC_CS_NONE = 2'h3
	} gtc_clksrc_t;

	// ======================================================
	// Control fields
	typedef struct packed {
		logic on;
		logic async;
		logic [1:0] presc;
	} gtc_ctrl_t;

	typedef struct packed {
		logic en;
		logic pol;
		logic [2:0] sel;
	} gtc_gate_t;

endpackage : gtc_pkg

/* File: logic/gtc_timer.sv */
// Gated 16-bit timer/counter with classic Wishbone register access
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
`include "gtc_params.svh"

module gtc_timer #(
	parameter int CW = 16,
	parameter int NGATE = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ext_count_i,
	input wire logic [NGATE-1:0] gate_src_i,
	input wire logic sleep_i,
	output logic ovf_flag_o,
	output logic wake_o
);

	// ======================================================
	// Elaboration checks
	if (CW != 16) begin : g_bad_cw
		$error("gtc_timer: count width must be 16");
	end
	if (NGATE != 8) begin : g_bad_ng
		$error("gtc_timer: eight gate sources are required");
	end

	localparam int NS = NGATE + 1;
	localparam logic [1:0] PH_LAST = 2'(`GTC_INSTR_CYC - 1);

	function automatic logic hit(input logic [7:0] adr,
		input logic [7:0] off);
		hit = (adr == off);
	endfunction : hit

	// ======================================================
	// State
	logic ack_q;
	logic [31:0] dat_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [2:0] ps_q;
	logic [2:0] ps_d;
	gtc_pkg::gtc_ctrl_t ctl_q;
	gtc_pkg::gtc_gate_t gc_q;
	gtc_pkg::gtc_clksrc_t cs_q;
	logic flag_q;
	logic wake_q;
	logic [1:0] ph_q;
	logic [NS-1:0] s1_q;
	logic [NS-1:0] s2_q;
	logic [NS-1:0] s3_q;
	logic [NS-1:0] filt_q;
	logic [NS-1:0] filt_d;
	logic ext_prev_q;
	logic arm_q;
	logic pend_q;

	// ======================================================
	// Bus decode
	wire req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wr_acc = req & wb_we_i & wb_sel_i[0];
	wire [7:0] wbyte = wb_dat_i[7:0];
	wire wr_low = wr_acc & hit(wb_adr_i, `GTC_OFF_LOW);
	wire wr_high = wr_acc & hit(wb_adr_i, `GTC_OFF_HIGH);
	wire wr_ctrl = wr_acc & hit(wb_adr_i, `GTC_OFF_CTRL);
	wire wr_gate = wr_acc & hit(wb_adr_i, `GTC_OFF_GATE);
	wire wr_csel = wr_acc & hit(wb_adr_i, `GTC_OFF_CSEL);
	wire wr_stat = wr_acc & hit(wb_adr_i, `GTC_OFF_STAT);
	wire cnt_wr = wr_low | wr_high;
	wire [CW-1:0] cnt_wr_val = wr_low ? {cnt_q[CW-1:8], wbyte}
		: {wbyte, cnt_q[7:0]};
	wire ovf_clr = wr_stat & wbyte[`GTC_ST_OVF];

	// ======================================================
	// Input filters: a change counts once stages two and three agree
	assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
	wire ext_lvl = filt_q[NGATE];
	wire ext_rise = ext_lvl & ~ext_prev_q;
	wire ext_fall = ~ext_lvl & ext_prev_q;
	wire gate_lvl = filt_q[gc_q.sel];

	// ======================================================
	// Clock events
	wire awake = ~sleep_i;
	wire instr_tick = (ph_q == PH_LAST) & awake;
	wire ext_ok = ext_rise & arm_q;
	// Sync mode holds an edge until the next instruction phase
	wire ext_sync_evt = (pend_q | ext_ok) & instr_tick;
	wire ext_evt = ctl_q.async ? ext_ok : ext_sync_evt;
	wire src_evt = (cs_q == gtc_pkg::GTC_CS_INSTR) ? instr_tick
		: (cs_q == gtc_pkg::GTC_CS_OSC) ? awake
		: (cs_q == gtc_pkg::GTC_CS_EXT) ? ext_evt
		: 1'b0;

	// ======================================================
	// Gating and prescaler
	wire gate_ok = ~gc_q.en | (gate_lvl == gc_q.pol);
	wire run = ctl_q.on & gate_ok;
	wire [2:0] ps_mask = (ctl_q.presc == 2'h0) ? 3'h0
		: (ctl_q.presc == 2'h1) ? 3'h1
		: (ctl_q.presc == 2'h2) ? 3'h3 : 3'h7;
	wire tick = run & src_evt;
	// Lowering the ratio mid-run must not count past the new mask
	wire ps_full = (ps_q >= ps_mask);
	wire adv = tick & ps_full & ~cnt_wr;
	wire ovf = adv & (&cnt_q);

	always_comb begin
		// A write beats a coinciding increment
		if (cnt_wr) begin
			ps_d = `GTC_RST_PS;
			cnt_d = cnt_wr_val;
		end else if (tick) begin
			ps_d = ps_full ? `GTC_RST_PS : 3'(ps_q + 3'h1);
			cnt_d = adv ? CW'(cnt_q + 1'b1) : cnt_q;
		end else begin
			ps_d = ps_q;
			cnt_d = cnt_q;
		end
	end

	// ======================================================
	// Read mux; the count lives in this domain so reads are coherent
	wire [31:0] rd_word =
		hit(wb_adr_i, `GTC_OFF_LOW) ? {24'h0, cnt_q[7:0]}
		: hit(wb_adr_i, `GTC_OFF_HIGH) ? {16'h0, 8'h0, cnt_q[CW-1:8]}
		: hit(wb_adr_i, `GTC_OFF_CTRL) ? {26'h0, ctl_q.presc, 1'b0,
			ctl_q.async, 1'b0, ctl_q.on}
		: hit(wb_adr_i, `GTC_OFF_GATE) ? {24'h0, gc_q.en, gc_q.pol,
			3'h0, gate_lvl, 2'h0}
		: hit(wb_adr_i, `GTC_OFF_CSEL) ? {25'h0, gc_q.sel, 2'h0, cs_q}
		: hit(wb_adr_i, `GTC_OFF_STAT) ? {31'h0, flag_q}
		: 32'h0;

	// ======================================================
	// Bus registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
		end else begin
			ack_q <= req;
			dat_q <= req ? rd_word : dat_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_q <= '0;
			gc_q <= '0;
			cs_q <= gtc_pkg::GTC_CS_INSTR;
		end else begin
			if (wr_ctrl) begin
				ctl_q.on <= wbyte[`GTC_CTL_ON];
				ctl_q.async <= wbyte[`GTC_CTL_ASYNC];
				ctl_q.presc <= wbyte[`GTC_CTL_PS_HI:`GTC_CTL_PS_LO];
			end
			if (wr_gate) begin
				gc_q.en <= wbyte[`GTC_GC_EN];
				gc_q.pol <= wbyte[`GTC_GC_POL];
			end
			if (wr_csel) begin
				cs_q <= gtc_pkg::gtc_clksrc_t'(
					wbyte[`GTC_CS_HI:`GTC_CS_LO]);
				gc_q.sel <= wbyte[`GTC_GS_HI:`GTC_GS_LO];
			end
		end
	end

	// ======================================================
	// Counter core
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= {`GTC_RST_BYTE, `GTC_RST_BYTE};
			ps_q <= `GTC_RST_PS;
			ph_q <= 2'h0;
		end else begin
			cnt_q <= cnt_d;
			ps_q <= ps_d;
			ph_q <= (ph_q == PH_LAST) ? 2'h0 : 2'(ph_q + 2'h1);
		end
	end

	// Set beats clear on the same edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			flag_q <= ovf | (flag_q & ~ovf_clr);
			wake_q <= ovf & sleep_i;
		end
	end

	// ======================================================
	// Synchronisers and external edge tracking
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			filt_q <= '0;
		end else begin
			s1_q <= {ext_count_i, gate_src_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
		end
	end

	// Disable or count write disarms: a fall must come first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_prev_q <= 1'b0;
			arm_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_lvl;
			if (~ctl_q.on | cnt_wr)
				arm_q <= 1'b0;
			else if (ext_fall)
				arm_q <= 1'b1;
			if (~ctl_q.on | cnt_wr | ctl_q.async | instr_tick)
				pend_q <= 1'b0;
			else if (ext_ok)
				pend_q <= 1'b1;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign ovf_flag_o = flag_q;
	assign wake_o = wake_q;

	// ======================================================
	// Assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_count_write;
		cnt_wr;
	endsequence

	sequence s_free_osc;
		ctl_q.on && !gc_q.en && cs_q == gtc_pkg::GTC_CS_OSC
			&& ctl_q.presc == 2'h0 && awake && !cnt_wr;
	endsequence

	a_write_load: assert property (
		s_count_write |=> cnt_q == $past(cnt_wr_val))
		else $error("count write not loaded");

	a_instr_rate: assert property (
		ctl_q.on && !gc_q.en && cs_q == gtc_pkg::GTC_CS_INSTR
			&& ctl_q.presc == 2'h0 && !cnt_wr && !instr_tick
		|=> cnt_q == $past(cnt_q))
		else $error("instruction timer moved off tick");

	a_off_hold: assert property (
		!ctl_q.on && !cnt_wr |=> $stable(cnt_q))
		else $error("count moved while off");

	a_osc_rate: assert property (
		s_free_osc |=> cnt_q == CW'($past(cnt_q) + 1'b1))
		else $error("oscillator source not counting each clock");

	a_ext_edge: assert property (
		ctl_q.on && ctl_q.async && !gc_q.en
			&& cs_q == gtc_pkg::GTC_CS_EXT && ctl_q.presc == 2'h0
			&& ext_rise && arm_q && !cnt_wr
		|=> cnt_q == CW'($past(cnt_q) + 1'b1))
		else $error("external rise not counted");

	a_arm_clear: assert property (
		s_count_write |=> !arm_q)
		else $error("write left the edge guard armed");

	a_ps_clear: assert property (
		s_count_write |=> ps_q == `GTC_RST_PS)
		else $error("prescaler survived count write");

	a_gate_hold: assert property (
		ctl_q.on && gc_q.en && gate_lvl != gc_q.pol && !cnt_wr
		|=> $stable(cnt_q) && $stable(ps_q))
		else $error("counted while gate closed");

	a_wrap_flag: assert property (
		ovf |=> cnt_q == '0 && flag_q)
		else $error("wrap did not clear count and set flag");

	a_flag_set_wins: assert property (
		ovf && ovf_clr |=> flag_q)
		else $error("flag clear beat a new overflow");

	a_sleep_wake: assert property (
		ovf && sleep_i |=> wake_q ##1 !wake_q || ovf)
		else $error("no wake pulse on sleep overflow");

	a_reset_off: assert property (
		@(posedge clk_i) disable iff (1'b0)
		rst_i |=> cnt_q == '0 && !ctl_q.on && ps_q == `GTC_RST_PS)
		else $error("reset left counter state");

	a_ack_pulse: assert property (
		ack_q |=> !ack_q)
		else $error("ack stood longer than one cycle");

	a_read_low: assert property (
		req && !wb_we_i && hit(wb_adr_i, `GTC_OFF_LOW)
		|=> wb_dat_o[7:0] == $past(cnt_q[7:0]))
		else $error("low byte read not the live count");

	a_sync_phase: assert property (
		ctl_q.on && !ctl_q.async && cs_q == gtc_pkg::GTC_CS_EXT
			&& !instr_tick && !cnt_wr
		|=> $stable(cnt_q))
		else $error("synchronous count moved off phase");

	a_sleep_stop: assert property (
		sleep_i && !(ctl_q.async && cs_q == gtc_pkg::GTC_CS_EXT)
			&& !cnt_wr
		|=> $stable(cnt_q))
		else $error("count moved in sleep without async source");

	a_arm_off: assert property (
		!ctl_q.on |=> !arm_q)
		else $error("edge guard armed while off");

	a_none_hold: assert property (
		cs_q == gtc_pkg::GTC_CS_NONE && !cnt_wr |=> $stable(cnt_q))
		else $error("count moved with no clock source");

	a_ps_wrap: assert property (
		tick && !cnt_wr && ps_full |=> ps_q == `GTC_RST_PS)
		else $error("prescaler ran past its ratio");

	a_flag_clear: assert property (
		ovf_clr && !ovf |=> !flag_q)
		else $error("flag survived its clear");

endmodule : gtc_timer

/* File: tb/gtc_timer_bench.sv */
// Self-checking bench of the gated timer, driven over classic Wishbone
`timescale 1ns/100ps
`define CHK(nm, e, s) begin \
	check_count++; \
	if ((s) !== (e)) begin \
		mismatches++; \
		$display("unexpected %s exp %h got %h", nm, e, s); \
	end \
end

module gtc_timer_bench;
	logic clk_i, rst_i, cyc, stb, we, ack, ext, sleep, ovf, wake;
	logic woke = 1'b0;
	logic [7:0] adr, rdat, gsrc;
	logic [31:0] dat, dato, rword;
	int mismatches = 0;
	int check_count = 0;

	gtc_timer i_gtc_timer (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
		.wb_dat_o(dato), .wb_ack_o(ack), .ext_count_i(ext),
		.gate_src_i(gsrc), .sleep_i(sleep), .ovf_flag_o(ovf),
		.wake_o(wake)
	);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Wake is a single pulse, so latch it for a later look
	always @(posedge clk_i) begin
		if (wake === 1'b1) woke <= 1'b1;
	end

	// ======================================================
	// Bus and stimulus tasks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic wb(input logic w, input logic [7:0] a, d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h000000, d};
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk_i);
		end
		if (n == 20) begin
			mismatches++;
			$display("unexpected %s exp %h got %h", "ack", 1'b1, ack);
			tally_and_finish();
		end else begin
			rword = dato;
			rdat = dato[7:0];
			cyc <= 1'b0;
			stb <= 1'b0;
			@(posedge clk_i);
		end
	endtask : wb

	task automatic rd(input logic [7:0] a, e);
		wb(1'b0, a, 8'h00);
		`CHK("read", e, rdat)
		`CHK("read upper", 24'h000000, rword[31:8])
	endtask : rd

	task automatic pulse();
		ext <= 1'b0;
		repeat (8) @(posedge clk_i);
		ext <= 1'b1;
		repeat (8) @(posedge clk_i);
	endtask : pulse

	// Counter is stopped around each write, so no write contention
	task automatic run(input logic [7:0] c, input int k, p,
			input logic [7:0] lo, hi);
		wb(1'b1, 8'h00, 8'h00);
		wb(1'b1, 8'h04, 8'h00);
		wb(1'b1, 8'h08, c);
		repeat (p) pulse();
		repeat (k) @(posedge clk_i);
		wb(1'b1, 8'h08, 8'h00);
		wb(1'b0, 8'h00, 8'h00);
		`CHK("count", 1'b1, rdat >= lo && rdat <= hi)
	endtask : run

	// ======================================================
	// Test sequence
	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat = 32'h00000000;
		ext = 1'b1;
		gsrc = 8'h00;
		sleep = 1'b0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int a = 0; a < 6; a++) rd(8'(a * 4), 8'h00);
		$display("test reset done");
		wb(1'b1, 8'h00, 8'hA5);
		wb(1'b1, 8'h04, 8'h3C);
		rd(8'h00, 8'hA5);
		rd(8'h04, 8'h3C);
		$display("test bytes done");
		run(8'h00, 32, 0, 8'h00, 8'h00);
		run(8'h01, 32, 0, 8'h07, 8'h0A);
		wb(1'b1, 8'h10, 8'h01);
		for (int p = 0; p < 4; p++) begin
			run(8'(p * 16 + 1), 64, 0, 8'(64 >> p), 8'((68 >> p) + 1));
		end
		wb(1'b1, 8'h10, 8'h03);
		run(8'h01, 32, 0, 8'h00, 8'h00);
		$display("test clock and prescale done");
		wb(1'b1, 8'h10, 8'h71);
		wb(1'b1, 8'h0C, 8'h80);
		run(8'h01, 32, 0, 8'h1E, 8'h25);
		wb(1'b1, 8'h0C, 8'hC0);
		run(8'h01, 32, 0, 8'h00, 8'h00);
		gsrc <= 8'h80;
		run(8'h01, 32, 0, 8'h1E, 8'h25);
		rd(8'h0C, 8'hC4);
		wb(1'b1, 8'h0C, 8'h00);
		$display("test gate done");
		wb(1'b1, 8'h10, 8'h02);
		run(8'h05, 8, 3, 8'h03, 8'h03);
		run(8'h01, 8, 3, 8'h03, 8'h03);
		ext <= 1'b0;
		run(8'h05, 8, 3, 8'h02, 8'h02);
		$display("test external done");
		wb(1'b1, 8'h00, 8'hFF);
		wb(1'b1, 8'h04, 8'hFF);
		sleep <= 1'b1;
		wb(1'b1, 8'h08, 8'h05);
		pulse();
		sleep <= 1'b0;
		`CHK("wake", 1'b1, woke)
		`CHK("ovf", 1'b1, ovf)
		wb(1'b1, 8'h08, 8'h00);
		rd(8'h00, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'h14, 8'h01);
		wb(1'b1, 8'h14, 8'h01);
		rd(8'h14, 8'h00);
		$display("test overflow done");
		tally_and_finish();
	end
endmodule : gtc_timer_bench
